// file: tss_clock_ctrl.sv
// system clock control: two-speed start-up, fail-safe monitor, control/status registers
// assumes every oscillator level and event input is synchronous to pclk and sampled
// well above its own frequency; sys_clk is a sampled image of the selected source
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module tss_clock_ctrl #(
    parameter int STARTUP_COUNT = tss_pkg::STARTUP_CYCLES,
    parameter int MON_DIV = tss_pkg::FAIL_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tss_pkg::tss_cfg_t cfg,
    input wire tss_pkg::tss_osc_stat_t osc_stat,
    input wire logic timer1_osc_enable,
    input wire logic ext_clk,
    input wire logic tmr1_clk,
    input wire logic int_clk,
    input wire logic lf_clk,
    input wire logic por_done,
    input wire logic sleep_req,
    input wire logic wake,
    output logic sys_clk,
    output logic cpu_hold,
    output tss_pkg::tss_src_t clk_src,
    output logic [3:0] freq_sel,
    output tss_pkg::tss_range_t freq_range,
    output logic pll_on,
    output logic osc_fail_flag,
    output logic osc_fail_irq
);

    localparam int CNTW = $clog2(STARTUP_COUNT + 1);
    localparam int DIVW = $clog2(MON_DIV);
    localparam logic [CNTW-1:0] CNT_LAST = CNTW'(STARTUP_COUNT - 1);
    localparam logic [DIVW-1:0] DIV_HALF = DIVW'(MON_DIV / 2 - 1);
    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(MON_DIV - 1);

    // the divider taps need a power of two
    if (STARTUP_COUNT < 2 || MON_DIV < 4 || (MON_DIV & (MON_DIV - 1)) != 0) begin
        $error("tss_clock_ctrl: bad timer or divider parameter");
    end

    typedef enum logic [2:0] {ST_WAIT_POR, ST_COUNT, ST_FALL_CUR, ST_FALL_NEW, ST_RUN, ST_SLEEP} tss_state_t;

    // =====================================================
    // helpers
    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == tss_pkg::MODE_LP) || (mode == tss_pkg::MODE_XT) || (mode == tss_pkg::MODE_HS);
    endfunction

    function automatic tss_pkg::tss_src_t sel_target(input logic [1:0] sel, input logic [2:0] mode);
        if (sel[1]) begin
            sel_target = tss_pkg::SRC_INT;
        end else if (sel == tss_pkg::SEL_T1) begin
            sel_target = tss_pkg::SRC_T1;
        end else if (mode == tss_pkg::MODE_INT_BLOCK) begin
            sel_target = tss_pkg::SRC_INT;
        end else begin
            sel_target = tss_pkg::SRC_CFG;
        end
    endfunction

    function automatic logic src_level(input tss_pkg::tss_src_t src, input logic e, input logic t, input logic i);
        case (src)
            tss_pkg::SRC_CFG: src_level = e;
            tss_pkg::SRC_T1: src_level = t;
            default: src_level = i;
        endcase
    endfunction

    // =====================================================
    // sampled clock levels and edges
    logic ext_q_r, t1_q_r, int_q_r, lf_q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q_r <= 1'b0;
            t1_q_r <= 1'b0;
            int_q_r <= 1'b0;
            lf_q_r <= 1'b0;
        end else begin
            ext_q_r <= ext_clk;
            t1_q_r <= tmr1_clk;
            int_q_r <= int_clk;
            lf_q_r <= lf_clk;
        end
    end

    tss_state_t state_r;
    tss_pkg::tss_src_t cur_src_r, tgt_src_r;
    logic [7:0] ctrl_r;
    logic fail_r, flag_r, ie_r, startup_stat_r, fail_det;

    logic lvl_now, lvl_prev, cur_fall, tgt_fall, lf_rise;
    always_comb begin
        lvl_now = src_level(cur_src_r, ext_clk, tmr1_clk, int_clk);
        lvl_prev = src_level(cur_src_r, ext_q_r, t1_q_r, int_q_r);
        cur_fall = lvl_prev & ~lvl_now;
        tgt_fall = src_level(tgt_src_r, ext_q_r, t1_q_r, int_q_r) & ~src_level(tgt_src_r, ext_clk, tmr1_clk, int_clk);
        lf_rise = lf_clk & ~lf_q_r;
    end

    // =====================================================
    // apb slave: no wait states, pready from a flop
    logic setup, access, wr_ctrl, wr_flag, wr_ie, sel_chg;
    logic [1:0] new_sel;
    logic mapped;

    always_comb begin
        setup = psel & ~penable & ~pready;
        access = psel & penable & pready;
        mapped = (paddr == tss_pkg::ADDR_OSC_CTRL) || (paddr == tss_pkg::ADDR_OSC_STAT)
              || (paddr == tss_pkg::ADDR_FAIL_FLAG) || (paddr == tss_pkg::ADDR_FAIL_IE);
        wr_ctrl = access & pwrite & (paddr == tss_pkg::ADDR_OSC_CTRL);
        wr_flag = access & pwrite & (paddr == tss_pkg::ADDR_FAIL_FLAG);
        wr_ie = access & pwrite & (paddr == tss_pkg::ADDR_FAIL_IE);
        new_sel = pwdata[tss_pkg::CTRL_SEL_LSB +: 2];
        sel_chg = wr_ctrl & (new_sel != ctrl_r[tss_pkg::CTRL_SEL_LSB +: 2]);
    end

    logic [7:0] stat_val;
    always_comb begin
        stat_val = {timer1_osc_enable ? osc_stat.t1_ready : 1'b1,
                    osc_stat.pll_ready, startup_stat_r, osc_stat.hf_ready,
                    osc_stat.hf_locked,
                    osc_stat.mf_ready, osc_stat.lf_ready,
                    osc_stat.hf_stable};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                case (paddr)
                    tss_pkg::ADDR_OSC_CTRL: prdata <= {24'h0, ctrl_r};
                    tss_pkg::ADDR_OSC_STAT: prdata <= {24'h0, stat_val};
                    tss_pkg::ADDR_FAIL_FLAG: prdata <= {30'h0, fail_r, flag_r};
                    tss_pkg::ADDR_FAIL_IE: prdata <= {31'h0, ie_r};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // oscillator_control; bit 2 unimplemented; automatic switches never touch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= tss_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= {pwdata[tss_pkg::CTRL_PLL_BIT], pwdata[tss_pkg::CTRL_FREQ_LSB +: 4], 1'b0, new_sel};
        end
    end

    // =====================================================
    // start-up sequencing
    logic [1:0] sel_eff;
    tss_pkg::tss_src_t start_tgt;
    logic start_evt, sleep_evt, needs_count, two_speed;
    logic [CNTW-1:0] start_cnt_r;

    always_comb begin
        sleep_evt = sleep_req & (state_r != ST_WAIT_POR) & (state_r != ST_SLEEP);
        start_evt = ((state_r == ST_WAIT_POR) & por_done) | ((state_r == ST_SLEEP) & wake) | sel_chg;
        sel_eff = sel_chg ? new_sel : ctrl_r[tss_pkg::CTRL_SEL_LSB +: 2];
        start_tgt = sel_target(sel_eff, cfg.mode);
        needs_count = (start_tgt == tss_pkg::SRC_T1) || ((start_tgt == tss_pkg::SRC_CFG) && is_crystal(cfg.mode));
        two_speed = (cfg.switchover | cfg.fail_monitor) & (sel_eff == tss_pkg::SEL_CFG) & is_crystal(cfg.mode);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_WAIT_POR;
            cur_src_r <= tss_pkg::SRC_INT;
            tgt_src_r <= tss_pkg::SRC_INT;
            start_cnt_r <= '0;
            cpu_hold <= 1'b1;
        end else if (sleep_evt) begin
            state_r <= ST_SLEEP;
            start_cnt_r <= '0;
            cpu_hold <= 1'b1;
        end else if (start_evt) begin
            tgt_src_r <= start_tgt;
            start_cnt_r <= '0;
            if (!sel_chg) begin
                cur_src_r <= tss_pkg::SRC_INT;
            end
            // without two-speed start-up the core waits for the crystal after power-on or wake
            cpu_hold <= !sel_chg && needs_count && (start_tgt == tss_pkg::SRC_CFG) && !two_speed;
            if (needs_count) begin
                state_r <= ST_COUNT;
            end else begin
                state_r <= ST_FALL_CUR;
            end
        end else begin
            case (state_r)
                ST_COUNT: begin
                    if (tgt_fall) begin
                        start_cnt_r <= start_cnt_r + CNTW'(1);
                        if (start_cnt_r == CNT_LAST) begin
                            state_r <= ST_FALL_CUR;
                        end
                    end
                end
                ST_FALL_CUR: begin
                    if (cur_fall || cur_src_r == tgt_src_r) begin
                        state_r <= ST_FALL_NEW;
                    end
                end
                ST_FALL_NEW: begin
                    if (tgt_fall) begin
                        cur_src_r <= tgt_src_r;
                        state_r <= ST_RUN;
                        cpu_hold <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (fail_det) begin
                        // a dead source has no falling edge to wait for: go straight to the hold
                        tgt_src_r <= tss_pkg::SRC_INT;
                        state_r <= ST_FALL_NEW;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // =====================================================
    // fail-safe monitor
    logic [DIVW-1:0] div_r;
    logic latch_r, mon_active, samp_rise, samp_fall;

    always_comb begin
        mon_active = cfg.fail_monitor && (state_r == ST_RUN) && (cur_src_r != tss_pkg::SRC_INT);
        samp_rise = lf_rise && (div_r == DIV_HALF);
        samp_fall = lf_rise && (div_r == DIV_LAST);
        fail_det = mon_active && samp_fall && !latch_r && !cur_fall;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else if (lf_rise) begin
            div_r <= div_r + DIVW'(1);
        end
    end

    // pre-set while idle so a half-cycle already in progress at start never reports a failure
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_r <= 1'b1;
        end else if (!mon_active || cur_fall) begin
            latch_r <= 1'b1;
        end else if (samp_rise) begin
            latch_r <= 1'b0;
        end
    end

    // =====================================================
    // fail condition, flag and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_r <= 1'b0;
        end else if (fail_det) begin
            fail_r <= 1'b1;
        end else if (sleep_evt || start_evt) begin
            fail_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else if (fail_det) begin
            flag_r <= 1'b1;
        end else if (wr_flag && pwdata[tss_pkg::FLAG_BIT] && !fail_r) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_r <= 1'b0;
        end else if (wr_ie) begin
            ie_r <= pwdata[tss_pkg::IE_BIT];
        end
    end

    // =====================================================
    // start-up status: set once the outgoing clock has fallen on the way to the configured source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            startup_stat_r <= 1'b0;
        end else if (sleep_evt || fail_det || start_evt) begin
            startup_stat_r <= 1'b0;
        end else if (state_r == ST_FALL_CUR && (cur_fall || cur_src_r == tgt_src_r)) begin
            startup_stat_r <= (tgt_src_r == tss_pkg::SRC_CFG);
        end
    end

    // =====================================================
    // outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk <= 1'b0;
            clk_src <= tss_pkg::SRC_INT;
            freq_sel <= tss_pkg::FREQ_RESET;
            freq_range <= tss_pkg::RANGE_MF;
            pll_on <= 1'b0;
            osc_fail_flag <= 1'b0;
            osc_fail_irq <= 1'b0;
        end else begin
            // a high phase always runs to its end and a new one starts only on a fresh rise,
            // so a hold, a sleep or a restart never cuts a pulse short
            if (state_r == ST_FALL_NEW || state_r == ST_SLEEP || state_r == ST_WAIT_POR) begin
                sys_clk <= sys_clk & lvl_now;
            end else begin
                sys_clk <= lvl_now & (sys_clk | ~lvl_prev);
            end
            clk_src <= cur_src_r;
            freq_sel <= ctrl_r[tss_pkg::CTRL_FREQ_LSB +: 4];
            if (ctrl_r[tss_pkg::CTRL_FREQ_LSB +: 4] < tss_pkg::FREQ_MF_FIRST) begin
                freq_range <= tss_pkg::RANGE_LF;
            end else if (ctrl_r[tss_pkg::CTRL_FREQ_LSB +: 4] < tss_pkg::FREQ_HF_FIRST) begin
                freq_range <= tss_pkg::RANGE_MF;
            end else begin
                freq_range <= tss_pkg::RANGE_HF;
            end
            pll_on <= cfg.pll | ctrl_r[tss_pkg::CTRL_PLL_BIT];
            osc_fail_flag <= flag_r;
            osc_fail_irq <= flag_r & ie_r;
        end
    end

endmodule

`default_nettype wire

// file: tss_pkg.sv
// constants, types and register map of the two-speed start-up / fail-safe clock block
// assumes a 32-bit apb slave port and oscillator levels sampled on pclk
`default_nettype none
package tss_pkg;

    // =====================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OSC_STAT = 8'h04;
    localparam logic [7:0] ADDR_FAIL_FLAG = 8'h08;
    localparam logic [7:0] ADDR_FAIL_IE = 8'h0c;

    // =====================================================
    // oscillator_control fields and reset value
    localparam int CTRL_PLL_BIT = 7;
    localparam int CTRL_FREQ_LSB = 3;
    localparam int CTRL_SEL_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h38;
    localparam logic [3:0] FREQ_RESET = 4'h7;
    localparam logic [1:0] SEL_CFG = 2'h0;
    localparam logic [1:0] SEL_T1 = 2'h1;

    // fail flag and fail interrupt enable register fields
    localparam int FLAG_BIT = 0;
    localparam int FAIL_ACTIVE_BIT = 1;
    localparam int IE_BIT = 0;

    // =====================================================
    // primary oscillator modes of the configuration word
    localparam logic [2:0] MODE_LP = 3'h0;
    localparam logic [2:0] MODE_XT = 3'h1;
    localparam logic [2:0] MODE_HS = 3'h2;
    localparam logic [2:0] MODE_RC = 3'h3;
    localparam logic [2:0] MODE_INT_BLOCK = 3'h4;

    // frequency select ranges
    localparam logic [3:0] FREQ_MF_FIRST = 4'h2;
    localparam logic [3:0] FREQ_HF_FIRST = 4'h8;

    // =====================================================
    // timing: the start-up timer counts source cycles, the monitor divides the lf clock
    localparam int STARTUP_CYCLES = 1024;
    localparam int FAIL_DIV = 64;

    typedef enum logic [1:0] {SRC_INT, SRC_CFG, SRC_T1} tss_src_t;
    typedef enum logic [1:0] {RANGE_LF, RANGE_MF, RANGE_HF} tss_range_t;

    typedef struct packed {
        logic switchover;
        logic fail_monitor;
        logic pll;
        logic [2:0] mode;
    } tss_cfg_t;

    typedef struct packed {
        logic t1_ready;
        logic pll_ready;
        logic hf_ready;
        logic hf_locked;
        logic mf_ready;
        logic lf_ready;
        logic hf_stable;
    } tss_osc_stat_t;

endpackage
`default_nettype wire

// file: tss_osc_model.sv
// oscillator sources seen by the clock block: crystal, timer1, internal, lf
// assumes a free-running pclk; every source is a pclk-aligned divider
`timescale 1ns/10ps
`default_nettype none
module tss_osc_model (
    input wire logic pclk,
    input wire logic ext_run,
    output logic ext_clk,
    output logic tmr1_clk,
    output logic int_clk,
    output logic lf_clk
);
    logic [7:0] cnt_r = 8'h00;

    // =====================================================
    // dividers; a dead crystal sticks high so no falling edge reaches the monitor
    always @(posedge pclk) begin
        cnt_r <= cnt_r + 8'h01;
    end
    assign int_clk = cnt_r[1];
    assign ext_clk = ext_run ? cnt_r[2] : 1'b1;
    assign lf_clk = ~cnt_r[2];
    assign tmr1_clk = cnt_r[3];
endmodule
`default_nettype wire

// file: tss_clock_ctrl_asserts.sv
// port-level assertions for the clock control block
// assumes it is bound to tss_clock_ctrl, one pclk domain
`timescale 1ns/10ps
`default_nettype none
module tss_clock_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire tss_pkg::tss_cfg_t cfg,
    input wire logic sleep_req,
    input wire logic sys_clk,
    input wire logic cpu_hold,
    input wire tss_pkg::tss_src_t clk_src,
    input wire logic [3:0] freq_sel,
    input wire tss_pkg::tss_range_t freq_range,
    input wire logic pll_on,
    input wire logic osc_fail_flag,
    input wire logic osc_fail_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // =====================================================
    // bus handshake
    a_setup_answer:
        assert property (psel && !penable |=> pready) else $error("no answer after setup");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("ready held too long");
    a_err_ready:
        assert property (pslverr |-> pready && psel && penable) else $error("error outside access");

    // =====================================================
    // clock control
    a_irq_flag:
        assert property (osc_fail_irq |-> osc_fail_flag) else $error("irq without flag");
    a_pll_forced:
        assert property ($past(presetn) && $past(cfg.pll) |-> pll_on) else $error("pll not forced on");
    a_range_map:
        assert property (freq_range == (freq_sel < tss_pkg::FREQ_MF_FIRST ? tss_pkg::RANGE_LF :
            freq_sel < tss_pkg::FREQ_HF_FIRST ? tss_pkg::RANGE_MF : tss_pkg::RANGE_HF))
        else $error("range does not match select");
    a_no_glitch:
        assert property ($rose(sys_clk) |=> sys_clk) else $error("short clock pulse");
    a_fail_internal:
        assert property ($rose(osc_fail_flag) |-> ##[0:20] clk_src == tss_pkg::SRC_INT)
        else $error("no fallback after failure");
    a_sleep_stop:
        assert property (sleep_req && !cpu_hold |-> ##[1:5] (cpu_hold && !sys_clk))
        else $error("sleep did not stop clock");
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the two-speed start-up and fail-safe clock block
// assumes tss_pkg, the oscillator model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    tss_pkg::tss_cfg_t cfg;
    tss_pkg::tss_osc_stat_t osc_stat;
    logic t1_en, ext_clk, tmr1_clk, int_clk, lf_clk, por_done, sleep_req, wake, ext_run;
    logic sys_clk, cpu_hold, pll_on, osc_fail_flag, osc_fail_irq;
    tss_pkg::tss_src_t clk_src;
    tss_pkg::tss_range_t freq_range;
    logic [3:0] freq_sel, f;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;

    always #5 pclk = ~pclk;

    // start-up count and monitor divider shortened to keep the run short
    tss_clock_ctrl #(.STARTUP_COUNT(8), .MON_DIV(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg(cfg), .osc_stat(osc_stat), .timer1_osc_enable(t1_en),
        .ext_clk(ext_clk), .tmr1_clk(tmr1_clk), .int_clk(int_clk), .lf_clk(lf_clk), .por_done(por_done),
        .sleep_req(sleep_req), .wake(wake), .sys_clk(sys_clk), .cpu_hold(cpu_hold), .clk_src(clk_src),
        .freq_sel(freq_sel), .freq_range(freq_range), .pll_on(pll_on), .osc_fail_flag(osc_fail_flag),
        .osc_fail_irq(osc_fail_irq));

    tss_osc_model u_osc (.pclk(pclk), .ext_run(ext_run), .ext_clk(ext_clk), .tmr1_clk(tmr1_clk),
        .int_clk(int_clk), .lf_clk(lf_clk));

    // =====================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after a rising edge; one idle cycle keeps psel from two updates in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_src(input tss_pkg::tss_src_t s);
        n = 0;
        while (clk_src !== s && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(clk_src, s);
    endtask

    task final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // =====================================================
    // tests
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cfg = '{1'b1, 1'b1, 1'b0, tss_pkg::MODE_XT};
        osc_stat = tss_pkg::tss_osc_stat_t'(7'h2d);
        t1_en = 1'b0;
        por_done = 1'b0;
        sleep_req = 1'b0;
        wake = 1'b0;
        ext_run = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, tss_pkg::ADDR_OSC_CTRL, 32'h0);
        chk(q, 32'h38);
        apb(1'b0, tss_pkg::ADDR_OSC_STAT, 32'h0);
        chk(q, 32'hcd);
        apb(1'b0, 8'h10, 32'h0);
        chk({q[30:0], e}, 32'h1);
        $display("reset test done");

        por_done <= 1'b1;
        @(posedge pclk);
        por_done <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({clk_src, cpu_hold}, {tss_pkg::SRC_INT, 1'b0});
        wait_src(tss_pkg::SRC_CFG);
        chk(32'(n > 52), 32'h1);
        apb(1'b0, tss_pkg::ADDR_OSC_STAT, 32'h0);
        chk(q, 32'hed);
        $display("start-up test done");

        for (int i = 0; i < 16; i++) begin
            f = i[3:0];
            apb(1'b1, tss_pkg::ADDR_OSC_CTRL, {24'h0, f[0], f, 3'b100});
            apb(1'b0, tss_pkg::ADDR_OSC_CTRL, 32'h0);
            chk(q, {24'h0, f[0], f, 3'b000});
            chk(freq_sel, f);
            chk(freq_range, (f < tss_pkg::FREQ_MF_FIRST) ? tss_pkg::RANGE_LF :
                (f < tss_pkg::FREQ_HF_FIRST) ? tss_pkg::RANGE_MF : tss_pkg::RANGE_HF);
            chk(pll_on, f[0]);
        end
        apb(1'b1, tss_pkg::ADDR_OSC_CTRL, 32'h38);
        $display("frequency test done");

        apb(1'b1, tss_pkg::ADDR_FAIL_IE, 32'h1);
        ext_run <= 1'b0;
        n = 0;
        while (osc_fail_flag !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        chk({osc_fail_flag, osc_fail_irq}, 32'h3);
        wait_src(tss_pkg::SRC_INT);
        apb(1'b1, tss_pkg::ADDR_FAIL_FLAG, 32'h1);
        apb(1'b0, tss_pkg::ADDR_FAIL_FLAG, 32'h0);
        chk(q, 32'h3);
        apb(1'b0, tss_pkg::ADDR_OSC_CTRL, 32'h0);
        chk(q, 32'h38);
        apb(1'b0, tss_pkg::ADDR_OSC_STAT, 32'h0);
        chk(q, 32'hcd);
        ext_run <= 1'b1;
        apb(1'b1, tss_pkg::ADDR_OSC_CTRL, 32'h3a);
        apb(1'b0, tss_pkg::ADDR_FAIL_FLAG, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, tss_pkg::ADDR_FAIL_FLAG, 32'h1);
        apb(1'b0, tss_pkg::ADDR_FAIL_FLAG, 32'h0);
        chk({q[30:0], osc_fail_flag}, 32'h0);
        apb(1'b1, tss_pkg::ADDR_OSC_CTRL, 32'h38);
        wait_src(tss_pkg::SRC_CFG);
        $display("fail-safe test done");

        t1_en <= 1'b1;
        apb(1'b0, tss_pkg::ADDR_OSC_STAT, 32'h0);
        chk(q, 32'h6d);
        apb(1'b1, tss_pkg::ADDR_OSC_CTRL, 32'h39);
        wait_src(tss_pkg::SRC_T1);
        chk(32'(n > 110), 32'h1);
        apb(1'b1, tss_pkg::ADDR_OSC_CTRL, 32'h38);
        wait_src(tss_pkg::SRC_CFG);
        $display("timer1 test done");

        for (int i = 0; i < 2; i++) begin
            sleep_req <= 1'b1;
            @(posedge pclk);
            sleep_req <= 1'b0;
            repeat (4) @(posedge pclk);
            chk(cpu_hold, 1'b1);
            wake <= 1'b1;
            @(posedge pclk);
            wake <= 1'b0;
            repeat (12) @(posedge pclk);
            chk(clk_src, tss_pkg::SRC_INT);
        end
        apb(1'b0, tss_pkg::ADDR_OSC_STAT, 32'h0);
        chk(q, 32'h4d);
        wait_src(tss_pkg::SRC_CFG);
        $display("sleep test done");

        presetn <= 1'b0;
        cfg <= '{1'b1, 1'b1, 1'b1, tss_pkg::MODE_RC};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        por_done <= 1'b1;
        @(posedge pclk);
        por_done <= 1'b0;
        wait_src(tss_pkg::SRC_CFG);
        chk({30'h0, n < 20, pll_on}, 32'h3);
        $display("rc mode test done");
        final_report();
    end
endmodule

bind tss_clock_ctrl tss_clock_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .cfg(cfg), .sleep_req(sleep_req),
    .sys_clk(sys_clk), .cpu_hold(cpu_hold), .clk_src(clk_src), .freq_sel(freq_sel),
    .freq_range(freq_range), .pll_on(pll_on), .osc_fail_flag(osc_fail_flag), .osc_fail_irq(osc_fail_irq));
`default_nettype wire
